// file: svi_pkg.sv
// Shared constants and types for the single-vector interrupt unit and its core end.
package svi_pkg;
  // Number of request sources; source i maps to pending bit i of {pending_flags_second[5:0], pending_flags_first}.
  localparam int SVI_NSRC = 14;
  localparam int SVI_SRC_W = 14;
  // Register addresses on the core register port.
  localparam logic [7:0] SVI_ADDR_MODE = 8'hDF;
  localparam logic [7:0] SVI_ADDR_PEND1 = 8'hD8;
  localparam logic [7:0] SVI_ADDR_PEND2 = 8'hD9;
  localparam logic [7:0] SVI_ADDR_EN1 = 8'hD6;
  localparam logic [7:0] SVI_ADDR_EN2 = 8'hD7;
  // Field positions and reset values.
  localparam int SVI_MODE_GIE_BIT = 3;
  localparam logic [7:0] SVI_MODE_RST = 8'h00;
  localparam logic [13:0] SVI_PEND_RST = 14'h0000;
  localparam logic [13:0] SVI_EN_RST = 14'h0000;
  // Vector bytes in program ROM: high byte first, then low byte.
  localparam logic [15:0] SVI_VEC_HI_ADDR = 16'h0000;
  localparam logic [15:0] SVI_VEC_LO_ADDR = 16'h0001;
  // Operations that the interrupt unit asks of the core.
  typedef enum logic [2:0] {
    SVI_OP_PUSH = 3'b000,
    SVI_OP_POP = 3'b001,
    SVI_OP_ROMRD = 3'b010,
    SVI_OP_JUMP = 3'b011,
    SVI_OP_RESTORE = 3'b100
  } svi_op_t;
  // APB register offsets of the core end.
  localparam logic [7:0] SVI_APB_CMD = 8'h00;
  localparam logic [7:0] SVI_APB_REGACC = 8'h04;
  localparam logic [7:0] SVI_APB_PC = 8'h08;
  localparam logic [7:0] SVI_APB_FLAGS = 8'h0C;
  localparam logic [7:0] SVI_APB_VECTOR = 8'h10;
  localparam logic [7:0] SVI_APB_SRCREQ = 8'h14;
  localparam logic [7:0] SVI_APB_STATUS = 8'h18;
  localparam logic [7:0] SVI_APB_ISTAT = 8'h1C;
  localparam logic [7:0] SVI_APB_IMASK = 8'h20;
  // Command bits of the CMD register.
  localparam int SVI_CMD_INSTR_END = 0;
  localparam int SVI_CMD_IRQ_ON = 1;
  localparam int SVI_CMD_IRQ_OFF = 2;
  localparam int SVI_CMD_RET = 3;
  localparam int SVI_CMD_REGWR = 4;
  // Event bits of the core end interrupt status register, ISTAT.
  localparam int SVI_EV_ACK = 0;
  localparam int SVI_EV_ENTRY = 1;
  localparam int SVI_EV_RETURN = 2;
  localparam int SVI_EV_W = 3;
  // Stack depth of the core end.
  localparam int SVI_STACK_DEPTH = 8;
endpackage : svi_pkg

// file: svi_if.sv
// Link between the interrupt unit and the core end.
`timescale 1ns/1ps
interface svi_if;
  import svi_pkg::*;
  logic [SVI_SRC_W-1:0] src_req; // Source request pulses.
  logic instr_end; // Current instruction ends this cycle.
  logic irq_on_pulse; // Enable interrupt instruction.
  logic irq_off_pulse; // Disable interrupt instruction.
  logic ret_pulse; // Interrupt return instruction.
  logic reg_we; // Register write strobe.
  logic [7:0] reg_addr; // Register address.
  logic [7:0] reg_wdata; // Register write data.
  logic [7:0] reg_rdata; // Register read data.
  logic [15:0] pc_cur; // Current program counter.
  logic [7:0] flags_cur; // Current flags.
  logic int_ack; // Interrupt acknowledge pulse.
  logic cyc_busy; // Interrupt machine cycle in progress.
  logic op_valid; // Operation request.
  logic op_ready; // Operation accepted.
  svi_op_t op_code; // Operation kind.
  logic [15:0] op_addr; // ROM address or branch target.
  logic [7:0] op_wdata; // Push data or flags to restore.
  logic [7:0] op_rdata; // Pop or ROM data.
  modport dev (input src_req, instr_end, irq_on_pulse, irq_off_pulse, ret_pulse, reg_we, reg_addr, reg_wdata,
               pc_cur, flags_cur, op_ready, op_rdata,
               output reg_rdata, int_ack, cyc_busy, op_valid, op_code, op_addr, op_wdata);
  modport core (output src_req, instr_end, irq_on_pulse, irq_off_pulse, ret_pulse, reg_we, reg_addr, reg_wdata,
                pc_cur, flags_cur, op_ready, op_rdata,
                input reg_rdata, int_ack, cyc_busy, op_valid, op_code, op_addr, op_wdata);
endinterface : svi_if

// file: svi_dev_end.sv
// Single-vector interrupt unit: pending, enables, global enable, entry and return sequences.
`timescale 1ns/1ps
module svi_dev_end
  import svi_pkg::*;
#(
  parameter int NSRC = SVI_NSRC
) (
  input wire logic CORE_CLK, // Core clock, 25 MHz.
  input wire logic RST_N, // Synchronous reset, active low.
  svi_if.dev LINK, // Link to the core end.
  output logic IRQ_PENDING, // Combined request to the core.
  output logic GIE_OUT, // Global enable bit.
  output logic BUSY // Interrupt machine cycle in progress.
);

  typedef enum logic [3:0] {
    SVI_ST_IDLE = 4'b0000,
    SVI_ST_PUSH_PCL = 4'b0001,
    SVI_ST_PUSH_PCH = 4'b0010,
    SVI_ST_PUSH_FLG = 4'b0011,
    SVI_ST_VEC_HI = 4'b0100,
    SVI_ST_VEC_LO = 4'b0101,
    SVI_ST_JUMP = 4'b0110,
    SVI_ST_POP_FLG = 4'b0111,
    SVI_ST_POP_PCH = 4'b1000,
    SVI_ST_POP_PCL = 4'b1001,
    SVI_ST_RESTORE = 4'b1010
  } svi_state_t;

  svi_state_t state_q;
  svi_state_t state_d;
  logic [NSRC-1:0] pend_q;
  logic [NSRC-1:0] pend_d;
  logic [NSRC-1:0] en_q;
  logic [7:0] mode_q;
  logic [15:0] pc_sv_q;
  logic [7:0] flg_sv_q;
  logic [15:0] vec_q;
  logic [15:0] ret_pc_q;
  logic [7:0] ret_flg_q;
  logic req;
  logic ack;
  logic ret_start;
  logic advance;
  logic idle;

  // True when a register write strobe hits the given address.
  function automatic logic wr_hit(input logic we, input logic [7:0] a, input logic [7:0] target);
    wr_hit = we && (a == target);
  endfunction : wr_hit

  // Combined request: pending AND own enable, ORed, gated by the global enable.
  // There is deliberately no priority encoder here; the handler polls the pending bits.
  assign req = mode_q[SVI_MODE_GIE_BIT] && (|(pend_q & en_q));
  assign idle = (state_q == SVI_ST_IDLE);
  // A return instruction ends an instruction too, so it wins over a new acknowledge in that cycle.
  assign ack = idle && LINK.instr_end && req && !LINK.ret_pulse;
  assign ret_start = idle && LINK.ret_pulse;
  assign advance = LINK.op_valid && LINK.op_ready;

  assign LINK.int_ack = ack;
  assign LINK.cyc_busy = !idle;
  assign IRQ_PENDING = req;
  assign GIE_OUT = mode_q[SVI_MODE_GIE_BIT];
  assign BUSY = !idle;

  // Pending bits: a source pulse sets its bit; a write ANDs the written value in.
  // Writing ones leaves bits alone, so a load with one zero clears just that source.
  // The set is ORed in last, so an event in the clearing cycle survives.
  always_comb begin
    pend_d = pend_q;
    if (wr_hit(LINK.reg_we, LINK.reg_addr, SVI_ADDR_PEND1)) begin
      pend_d[7:0] = pend_q[7:0] & LINK.reg_wdata;
    end
    if (wr_hit(LINK.reg_we, LINK.reg_addr, SVI_ADDR_PEND2)) begin
      pend_d[NSRC-1:8] = pend_q[NSRC-1:8] & LINK.reg_wdata[NSRC-9:0];
    end
    pend_d = pend_d | LINK.src_req[NSRC-1:0];
  end

  // Pending register; acknowledge does not touch it.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pend_q <= SVI_PEND_RST;
    end else begin
      pend_q <= pend_d;
    end
  end

  // Source enables, standing in for the enable bits of each peripheral control register.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      en_q <= SVI_EN_RST;
    end else begin
      if (wr_hit(LINK.reg_we, LINK.reg_addr, SVI_ADDR_EN1)) begin
        en_q[7:0] <= LINK.reg_wdata;
      end
      if (wr_hit(LINK.reg_we, LINK.reg_addr, SVI_ADDR_EN2)) begin
        en_q[NSRC-1:8] <= LINK.reg_wdata[NSRC-9:0];
      end
    end
  end

  // System mode register; hardware entry and return act after software, so they win.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      mode_q <= SVI_MODE_RST;
    end else begin
      if (wr_hit(LINK.reg_we, LINK.reg_addr, SVI_ADDR_MODE)) begin
        mode_q <= LINK.reg_wdata;
      end
      if (LINK.irq_on_pulse) begin
        mode_q[SVI_MODE_GIE_BIT] <= 1'b1;
      end
      if (LINK.irq_off_pulse) begin
        mode_q[SVI_MODE_GIE_BIT] <= 1'b0;
      end
      if (ack) begin
        mode_q[SVI_MODE_GIE_BIT] <= 1'b0;
      end
      if (state_q == SVI_ST_RESTORE && advance) begin
        mode_q[SVI_MODE_GIE_BIT] <= 1'b1;
      end
    end
  end

  // Register read path; unmapped addresses and unused bits read zero.
  always_comb begin
    LINK.reg_rdata = 8'h00;
    case (LINK.reg_addr)
      SVI_ADDR_MODE: LINK.reg_rdata = mode_q;
      SVI_ADDR_PEND1: LINK.reg_rdata = pend_q[7:0];
      SVI_ADDR_PEND2: LINK.reg_rdata[NSRC-9:0] = pend_q[NSRC-1:8];
      SVI_ADDR_EN1: LINK.reg_rdata = en_q[7:0];
      SVI_ADDR_EN2: LINK.reg_rdata[NSRC-9:0] = en_q[NSRC-1:8];
      default: LINK.reg_rdata = 8'h00;
    endcase
  end

  // Sequencer for the entry and return machine cycles.
  always_comb begin
    state_d = state_q;
    case (state_q)
      SVI_ST_IDLE: begin
        if (ack) begin
          state_d = SVI_ST_PUSH_PCL;
        end else if (ret_start) begin
          state_d = SVI_ST_POP_FLG;
        end
      end
      SVI_ST_PUSH_PCL: if (advance) state_d = SVI_ST_PUSH_PCH;
      SVI_ST_PUSH_PCH: if (advance) state_d = SVI_ST_PUSH_FLG;
      SVI_ST_PUSH_FLG: if (advance) state_d = SVI_ST_VEC_HI;
      SVI_ST_VEC_HI: if (advance) state_d = SVI_ST_VEC_LO;
      SVI_ST_VEC_LO: if (advance) state_d = SVI_ST_JUMP;
      SVI_ST_JUMP: if (advance) state_d = SVI_ST_IDLE;
      SVI_ST_POP_FLG: if (advance) state_d = SVI_ST_POP_PCH;
      SVI_ST_POP_PCH: if (advance) state_d = SVI_ST_POP_PCL;
      SVI_ST_POP_PCL: if (advance) state_d = SVI_ST_RESTORE;
      SVI_ST_RESTORE: if (advance) state_d = SVI_ST_IDLE;
      default: state_d = SVI_ST_IDLE;
    endcase
  end

  // State register.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      state_q <= SVI_ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Context captured at acknowledge, so the core may not change it under us.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pc_sv_q <= 16'h0000;
      flg_sv_q <= 8'h00;
    end else if (ack) begin
      pc_sv_q <= LINK.pc_cur;
      flg_sv_q <= LINK.flags_cur;
    end
  end

  // Vector assembly: high byte from ROM 0, low byte from ROM 1.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      vec_q <= 16'h0000;
    end else if (advance && state_q == SVI_ST_VEC_HI) begin
      vec_q[15:8] <= LINK.op_rdata;
    end else if (advance && state_q == SVI_ST_VEC_LO) begin
      vec_q[7:0] <= LINK.op_rdata;
    end
  end

  // Values popped on return, in reverse order of the pushes.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ret_pc_q <= 16'h0000;
      ret_flg_q <= 8'h00;
    end else if (advance) begin
      case (state_q)
        SVI_ST_POP_FLG: ret_flg_q <= LINK.op_rdata;
        SVI_ST_POP_PCH: ret_pc_q[15:8] <= LINK.op_rdata;
        SVI_ST_POP_PCL: ret_pc_q[7:0] <= LINK.op_rdata;
        default: ret_pc_q <= ret_pc_q;
      endcase
    end
  end

  // Operation presented to the core in each state; every field comes from flip-flops.
  always_comb begin
    LINK.op_valid = 1'b1;
    LINK.op_code = SVI_OP_PUSH;
    LINK.op_addr = 16'h0000;
    LINK.op_wdata = 8'h00;
    case (state_q)
      SVI_ST_PUSH_PCL: LINK.op_wdata = pc_sv_q[7:0];
      SVI_ST_PUSH_PCH: LINK.op_wdata = pc_sv_q[15:8];
      SVI_ST_PUSH_FLG: LINK.op_wdata = flg_sv_q;
      SVI_ST_VEC_HI: begin
        LINK.op_code = SVI_OP_ROMRD;
        LINK.op_addr = SVI_VEC_HI_ADDR;
      end
      SVI_ST_VEC_LO: begin
        LINK.op_code = SVI_OP_ROMRD;
        LINK.op_addr = SVI_VEC_LO_ADDR;
      end
      SVI_ST_JUMP: begin
        LINK.op_code = SVI_OP_JUMP;
        LINK.op_addr = vec_q;
      end
      SVI_ST_POP_FLG, SVI_ST_POP_PCH, SVI_ST_POP_PCL: LINK.op_code = SVI_OP_POP;
      SVI_ST_RESTORE: begin
        LINK.op_code = SVI_OP_RESTORE;
        LINK.op_addr = ret_pc_q;
        LINK.op_wdata = ret_flg_q;
      end
      default: LINK.op_valid = 1'b0;
    endcase
  end

endmodule : svi_dev_end

// file: svi_core_end.sv
// Core end: APB-controlled stand-in for the CPU and the request sources, with stack, ROM vector and PC.
`timescale 1ns/1ps
module svi_core_end
  import svi_pkg::*;
#(
  parameter int DEPTH = SVI_STACK_DEPTH
) (
  input wire logic CORE_CLK, // Core clock, 25 MHz.
  input wire logic RST_N, // Synchronous reset, active low.
  input wire logic PSEL, // APB select.
  input wire logic PENABLE, // APB access phase.
  input wire logic PWRITE, // APB direction.
  input wire logic [7:0] PADDR, // APB byte address.
  input wire logic [31:0] PWDATA, // APB write data.
  output logic [31:0] PRDATA, // APB read data.
  output logic PREADY, // APB ready, always high.
  output logic PSLVERR, // APB error on unmapped address.
  output logic IRQ, // Level interrupt to software.
  svi_if.core LINK // Link to the interrupt unit.
);

  localparam int SPW = $clog2(DEPTH);
  logic [7:0] stack_q [DEPTH];
  logic [SPW-1:0] sp_q;
  logic [15:0] pc_q;
  logic [7:0] flags_q;
  logic [15:0] rom_q;
  logic [15:0] regacc_q;
  logic [7:0] rd_q;
  logic [4:0] cmd_q;
  logic [SVI_SRC_W-1:0] src_q;
  logic [SVI_EV_W-1:0] istat_q;
  logic [SVI_EV_W-1:0] imask_q;
  logic [SVI_EV_W-1:0] ev;
  logic wr;
  logic mapped;
  logic op_do;

  // Zero-wait slave: every access completes in its first access cycle.
  assign wr = PSEL && PENABLE && PWRITE;
  assign PREADY = 1'b1;
  assign op_do = LINK.op_valid && LINK.op_ready;
  // The core always accepts at once; a real core would stall here for memory.
  assign LINK.op_ready = LINK.op_valid;
  assign LINK.pc_cur = pc_q;
  assign LINK.flags_cur = flags_q;
  assign LINK.src_req = src_q;
  assign LINK.instr_end = cmd_q[SVI_CMD_INSTR_END];
  assign LINK.irq_on_pulse = cmd_q[SVI_CMD_IRQ_ON];
  assign LINK.irq_off_pulse = cmd_q[SVI_CMD_IRQ_OFF];
  assign LINK.ret_pulse = cmd_q[SVI_CMD_RET];
  assign LINK.reg_we = cmd_q[SVI_CMD_REGWR];
  assign LINK.reg_addr = regacc_q[7:0];
  assign LINK.reg_wdata = regacc_q[15:8];
  assign ev = {op_do && LINK.op_code == SVI_OP_RESTORE, op_do && LINK.op_code == SVI_OP_JUMP, LINK.int_ack};
  assign IRQ = |(istat_q & imask_q);

  // Pop data comes from the slot below the pointer; ROM reads return the vector bytes.
  always_comb begin
    LINK.op_rdata = 8'h00;
    if (LINK.op_code == SVI_OP_POP) begin
      LINK.op_rdata = stack_q[sp_q - SPW'(1)];
    end else if (LINK.op_code == SVI_OP_ROMRD) begin
      LINK.op_rdata = (LINK.op_addr == SVI_VEC_HI_ADDR) ? rom_q[7:0] : rom_q[15:8];
    end
  end

  // Command and source strobes last one cycle after the APB write.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      cmd_q <= 5'h00;
      src_q <= '0;
    end else begin
      cmd_q <= (wr && PADDR == SVI_APB_CMD) ? PWDATA[4:0] : 5'h00;
      src_q <= (wr && PADDR == SVI_APB_SRCREQ) ? PWDATA[SVI_SRC_W-1:0] : '0;
    end
  end

  // Software registers; branch and restore from the interrupt unit win over software.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pc_q <= 16'h0000;
      flags_q <= 8'h00;
      rom_q <= 16'h0000;
      regacc_q <= 16'h0000;
      imask_q <= '0;
      rd_q <= 8'h00;
    end else begin
      rd_q <= LINK.reg_rdata;
      if (wr && PADDR == SVI_APB_PC) pc_q <= PWDATA[15:0];
      if (wr && PADDR == SVI_APB_FLAGS) flags_q <= PWDATA[7:0];
      if (wr && PADDR == SVI_APB_VECTOR) rom_q <= PWDATA[15:0];
      if (wr && PADDR == SVI_APB_REGACC) regacc_q <= PWDATA[15:0];
      if (wr && PADDR == SVI_APB_IMASK) imask_q <= PWDATA[SVI_EV_W-1:0];
      if (op_do && LINK.op_code == SVI_OP_JUMP) pc_q <= LINK.op_addr;
      if (op_do && LINK.op_code == SVI_OP_RESTORE) begin
        pc_q <= LINK.op_addr;
        flags_q <= LINK.op_wdata;
      end
    end
  end

  // Stack: push writes then increments, pop decrements.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sp_q <= '0;
    end else if (op_do && LINK.op_code == SVI_OP_PUSH) begin
      stack_q[sp_q] <= LINK.op_wdata;
      sp_q <= sp_q + SPW'(1);
    end else if (op_do && LINK.op_code == SVI_OP_POP) begin
      sp_q <= sp_q - SPW'(1);
    end
  end

  // Sticky events, write one to clear; a new event in the clearing cycle wins.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      istat_q <= '0;
    end else begin
      istat_q <= (istat_q & ~((wr && PADDR == SVI_APB_ISTAT) ? PWDATA[SVI_EV_W-1:0] : '0)) | ev;
    end
  end

  // Read mux and error for unmapped addresses.
  always_comb begin
    PRDATA = 32'h0000_0000;
    mapped = 1'b1;
    case (PADDR)
      SVI_APB_CMD: PRDATA = 32'h0000_0000;
      SVI_APB_REGACC: PRDATA = {8'h00, rd_q, regacc_q};
      SVI_APB_PC: PRDATA = {16'h0000, pc_q};
      SVI_APB_FLAGS: PRDATA = {24'h000000, flags_q};
      SVI_APB_VECTOR: PRDATA = {16'h0000, rom_q};
      SVI_APB_SRCREQ: PRDATA = 32'h0000_0000;
      SVI_APB_STATUS: PRDATA = {16'h0000, 8'(sp_q), 7'h00, LINK.cyc_busy};
      SVI_APB_ISTAT: PRDATA = {29'h0, istat_q};
      SVI_APB_IMASK: PRDATA = {29'h0, imask_q};
      default: mapped = 1'b0;
    endcase
    PSLVERR = PSEL && PENABLE && !mapped;
  end

endmodule : svi_core_end

// file: svi_props.sv
// Concurrent checks on the link between the interrupt unit and its core end.
`timescale 1ns/1ps
module svi_props
  import svi_pkg::*;
(
  input wire logic CORE_CLK, // Clock.
  input wire logic RST_N, // Reset, active low.
  input wire logic instr_end, // Instruction end.
  input wire logic irq_on_pulse, // Enable instruction.
  input wire logic ret_pulse, // Return instruction.
  input wire logic reg_we, // Register write.
  input wire logic [7:0] reg_addr, // Register address.
  input wire logic [7:0] reg_wdata, // Register data.
  input wire logic [15:0] pc_cur, // Program counter.
  input wire logic [7:0] flags_cur, // Flags.
  input wire logic int_ack, // Acknowledge.
  input wire logic cyc_busy, // Machine cycle.
  input wire svi_op_t op_code, // Operation kind.
  input wire logic [15:0] op_addr, // Operation address.
  input wire logic [7:0] op_wdata, // Operation data out.
  input wire logic [7:0] op_rdata // Operation data in.
);
  logic seen_q;
  logic [7:0] pc_lo;
  logic [7:0] pc_hi;
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);
  // Byte views of the counter, so that $past is handed a plain signal.
  assign pc_lo = pc_cur[7:0];
  assign pc_hi = pc_cur[15:8];
  // An acknowledge before any enable would mean service ran while disabled.
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N)
      seen_q <= 1'b0;
    else if (irq_on_pulse || (reg_we && reg_addr == SVI_ADDR_MODE && reg_wdata[SVI_MODE_GIE_BIT]))
      seen_q <= 1'b1;
  end
  property p_ack_at_end; int_ack |-> instr_end && !ret_pulse; endproperty
  property p_ack_idle; cyc_busy |-> !int_ack; endproperty
  property p_no_early_ack; !seen_q |-> !int_ack; endproperty
  property p_push_order;
    int_ack |-> ##1 (op_code == SVI_OP_PUSH && op_wdata == $past(pc_lo)) ##1 (op_code == SVI_OP_PUSH &&
      op_wdata == $past(pc_hi, 2)) ##1 (op_code == SVI_OP_PUSH && op_wdata == $past(flags_cur, 3));
  endproperty
  property p_vec_fetch;
    int_ack |-> ##4 (op_code == SVI_OP_ROMRD && op_addr == SVI_VEC_HI_ADDR) ##1
      (op_code == SVI_OP_ROMRD && op_addr == SVI_VEC_LO_ADDR);
  endproperty
  property p_branch;
    int_ack |-> ##6 (op_code == SVI_OP_JUMP && op_addr == {$past(op_rdata, 2), $past(op_rdata)});
  endproperty
  property p_busy_span; int_ack |=> cyc_busy [*6]; endproperty
  property p_return;
    ret_pulse && !cyc_busy |-> ##1 (op_code == SVI_OP_POP) [*3] ##1 (op_code == SVI_OP_RESTORE &&
      op_addr == {$past(op_rdata, 2), $past(op_rdata)} && op_wdata == $past(op_rdata, 3));
  endproperty
  a_ack_at_end: assert property (p_ack_at_end) else $error("ack off instruction end");
  a_ack_idle: assert property (p_ack_idle) else $error("ack during machine cycle");
  a_no_early_ack: assert property (p_no_early_ack) else $error("ack before enable");
  a_push_order: assert property (p_push_order) else $error("push order wrong");
  a_vec_fetch: assert property (p_vec_fetch) else $error("vector fetch wrong");
  a_branch: assert property (p_branch) else $error("branch target wrong");
  a_busy_span: assert property (p_busy_span) else $error("machine cycle short");
  a_return: assert property (p_return) else $error("return sequence wrong");
  c_entry: cover property (int_ack);
  c_return: cover property (ret_pulse && !cyc_busy);
  c_pend_wr: cover property (reg_we && reg_addr == SVI_ADDR_PEND1);
endmodule : svi_props

// file: single_vector_interrupt_unit_test.sv
// Self-checking bench: APB-driven core end facing the interrupt unit.
`timescale 1ns/1ps
module single_vector_interrupt_unit_test;
  import svi_pkg::*;
  typedef struct {string n; logic [31:0] e; logic [31:0] m; logic er;} svi_note_t;
  logic clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, irq_pend, gie, busy;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [15:0] pc0, vec;
  logic [7:0] fl0;
  logic [13:0] pend;
  int num_errors = 0;
  int num_checks = 0;
  svi_note_t notes[$];
  svi_note_t nt;
  svi_if link();
  svi_dev_end u_svi_dev_end (.CORE_CLK(clk), .RST_N(rst_n), .LINK(link), .IRQ_PENDING(irq_pend), .GIE_OUT(gie),
    .BUSY(busy));
  svi_core_end u_svi_core_end (.CORE_CLK(clk), .RST_N(rst_n), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .IRQ(irq), .LINK(link));
  svi_props u_svi_props (.CORE_CLK(clk), .RST_N(rst_n), .instr_end(link.instr_end), .irq_on_pulse(link.irq_on_pulse),
    .ret_pulse(link.ret_pulse), .reg_we(link.reg_we), .reg_addr(link.reg_addr), .reg_wdata(link.reg_wdata),
    .pc_cur(link.pc_cur), .flags_cur(link.flags_cur), .int_ack(link.int_ack), .cyc_busy(link.cyc_busy),
    .op_code(link.op_code), .op_addr(link.op_addr), .op_wdata(link.op_wdata), .op_rdata(link.op_rdata));
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask : check
  task automatic flag(input string n, input logic s, input logic e);
    @(posedge clk);
    check(n, {31'h0, s}, {31'h0, e});
  endtask : flag
  // One APB transfer; the request holds until pready is seen at an edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // No wait limit of its own; a slave that never answers is caught by the watchdog.
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e, input logic [31:0] m,
    input logic er = 1'b0);
    notes.push_back('{n, e, m, er});
    apb(1'b0, a, 32'h0);
  endtask : rd
  task automatic dwr(input logic [7:0] a, input logic [7:0] d);
    apb(1'b1, SVI_APB_REGACC, {16'h0000, d, a});
    apb(1'b1, SVI_APB_CMD, 32'h1 << SVI_CMD_REGWR);
    repeat (3) @(posedge clk);
  endtask : dwr
  // Device reads land in REGACC a cycle late, so wait before fetching them.
  task automatic drd(input string n, input logic [7:0] a, input logic [7:0] e);
    apb(1'b1, SVI_APB_REGACC, {24'h000000, a});
    repeat (2) @(posedge clk);
    rd(n, SVI_APB_REGACC, {8'h00, e, 16'h0000}, 32'h00FF0000);
  endtask : drd
  task automatic cmd(input int b);
    apb(1'b1, SVI_APB_CMD, 32'h1 << b);
    repeat (3) @(posedge clk);
  endtask : cmd
  // A machine cycle that never ends runs into the watchdog and fails the run.
  task automatic settle;
    while (busy !== 1'b0) begin
      @(posedge clk);
    end
  endtask : settle
  task automatic complete_run;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run
  // Clock of 40 ns.
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // Read data only stands in the access cycle, so it is taken at that edge.
  always @(posedge clk) begin
    if (psel && penable && pready && !pwrite) begin
      nt = notes.pop_front();
      check(nt.n, prdata & nt.m, nt.e);
      check("slverr", {31'h0, pslverr}, {31'h0, nt.er});
    end
  end
  // Watchdog far beyond the few hundred cycles the tests need.
  initial begin
    repeat (20000) @(posedge clk);
    num_errors++;
    complete_run();
  end
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(32'h015215c0));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    // Reset state and an unmapped offset.
    flag("gie", gie, 1'b0);
    drd("mode", SVI_ADDR_MODE, SVI_MODE_RST);
    rd("unmapped", 8'h40, 32'h0, 32'hFFFFFFFF, 1'b1);
    $display("test reset done");
    // A request stays pending while either enable is off.
    apb(1'b1, SVI_APB_SRCREQ, 32'h4);
    drd("pend", SVI_ADDR_PEND1, 8'h04);
    cmd(SVI_CMD_IRQ_ON);
    flag("gie", gie, 1'b1);
    cmd(SVI_CMD_INSTR_END);
    rd("istat", SVI_APB_ISTAT, 32'h0, 32'h7);
    cmd(SVI_CMD_IRQ_OFF);
    dwr(SVI_ADDR_EN1, 8'h04);
    flag("req", irq_pend, 1'b0);
    cmd(SVI_CMD_INSTR_END);
    rd("istat", SVI_APB_ISTAT, 32'h0, 32'h7);
    dwr(SVI_ADDR_MODE, 8'h08);
    flag("req", irq_pend, 1'b1);
    $display("test gating done");
    // Entry with random context and vector.
    pc0 = 16'($urandom());
    fl0 = 8'($urandom());
    vec = 16'($urandom());
    apb(1'b1, SVI_APB_PC, {16'h0000, pc0});
    apb(1'b1, SVI_APB_FLAGS, {24'h000000, fl0});
    apb(1'b1, SVI_APB_VECTOR, {16'h0000, vec});
    cmd(SVI_CMD_INSTR_END);
    settle();
    rd("pc", SVI_APB_PC, {16'h0000, vec[7:0], vec[15:8]}, 32'h0000FFFF);
    flag("gie", gie, 1'b0);
    drd("mode", SVI_ADDR_MODE, 8'h00);
    rd("istat", SVI_APB_ISTAT, 32'h3, 32'h7);
    rd("stack", SVI_APB_STATUS, 32'h0300, 32'h0000FF01);
    drd("pend", SVI_ADDR_PEND1, 8'h04);
    flag("irq", irq, 1'b0);
    apb(1'b1, SVI_APB_IMASK, 32'h1);
    // The mask lands at the access edge, so the level is looked at one cycle later.
    @(posedge clk);
    flag("irq", irq, 1'b1);
    apb(1'b1, SVI_APB_ISTAT, 32'h3);
    @(posedge clk);
    flag("irq", irq, 1'b0);
    $display("test entry done");
    // Handler clears its bit, then the return restores the context.
    dwr(SVI_ADDR_PEND1, 8'hFB);
    drd("pend", SVI_ADDR_PEND1, 8'h00);
    apb(1'b1, SVI_APB_PC, {16'h0000, ~pc0});
    cmd(SVI_CMD_RET);
    settle();
    rd("pc", SVI_APB_PC, {16'h0000, pc0}, 32'h0000FFFF);
    rd("flags", SVI_APB_FLAGS, {24'h000000, fl0}, 32'h000000FF);
    flag("gie", gie, 1'b1);
    rd("istat", SVI_APB_ISTAT, 32'h4, 32'h7);
    rd("stack", SVI_APB_STATUS, 32'h0, 32'h0000FF01);
    $display("test return done");
    // Each source sets its own bit only; nothing is taken without an instruction end.
    pend = 14'h0000;
    for (int i = 0; i < SVI_NSRC; i++) begin
      pend[i] = 1'b1;
      apb(1'b1, SVI_APB_SRCREQ, 32'h1 << i);
      if (i < 8)
        drd("pend1", SVI_ADDR_PEND1, pend[7:0]);
      else
        drd("pend2", SVI_ADDR_PEND2, {2'b00, pend[13:8]});
    end
    rd("istat", SVI_APB_ISTAT, 32'h4, 32'h7);
    dwr(SVI_ADDR_PEND2, 8'hF7);
    drd("pend2", SVI_ADDR_PEND2, 8'h37);
    cmd(SVI_CMD_IRQ_OFF);
    flag("gie", gie, 1'b0);
    $display("test sources done");
    complete_run();
  end
endmodule : single_vector_interrupt_unit_test
